// [rtl/imt_defines.svh]
`ifndef IMT_DEFINES_SVH
`define IMT_DEFINES_SVH
// APB byte offsets
`define IMT_OFS_CTRL 12'h000
`define IMT_OFS_MDC 12'h004
`define IMT_OFS_TRAP 12'h008
`define IMT_OFS_STAT 12'h00C
`define IMT_OFS_ISTAT 12'h010
`define IMT_OFS_ICLR 12'h014
`define IMT_OFS_IEN 12'h018
// Control register fields
`define IMT_CTRL_GIE 0
`define IMT_CTRL_MULTIPLY_IN_PROGRESS_FLAG 1
`define IMT_CTRL_LVL_LSB 4
`define IMT_CTRL_UPPER_LSB 8
// Trap flag fields
`define IMT_TRAP_NMI 0
`define IMT_TRAP_STACK_OVERFLOW_FLAG 1
`define IMT_TRAP_STACK_UNDERFLOW_FLAG 2
// Event bits
`define IMT_EV_TRAP 0
`define IMT_EV_INT 1
`define IMT_EV_MULDONE 2
// Values
`define IMT_MDC_RESTART 16'h0000
`define IMT_UPPER_BLOCK 8'hF0
`define IMT_LVL_MAX 4'hF
`define IMT_MUL_CYCLES 5'h10
`define IMT_TRAP_DELAY_MAX 2'h2
`endif

// [rtl/imt_pkg.sv]
package imt_pkg;
  typedef enum logic [1:0] {
    IMT_IDLE = 2'b00,
    IMT_MUL = 2'b01,
    IMT_SERVICE = 2'b10,
    IMT_TRAP = 2'b11
  } imt_mode_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } imt_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } imt_apb_rsp_type;

  typedef struct packed {
    logic instr_retire;
    logic mul_start;
    logic return_from_interrupt_instr;
    logic int_req;
    logic [3:0] int_level;
    logic pec_req;
    logic hw_trap_req;
  } imt_core_in_type;

  typedef struct packed {
    logic mul_active;
    logic mul_restart;
    logic mul_done;
    logic int_ack;
    logic pec_ack;
    logic trap_enter;
    logic [4:0] mul_step;
  } imt_core_out_type;

  typedef struct packed {
    imt_mode_type mode;
    logic gie;
    logic multiply_in_progress_flag;
    logic [3:0] level;
    logic [3:0] saved_level;
    logic [7:0] upper;
    logic [15:0] mdc;
    logic [2:0] trap_flags;
    logic [1:0] trap_wait;
    logic trap_pending;
    logic class_a;
    logic [2:0] istat;
    logic [2:0] global_interrupt_enable;
    logic irq;
    imt_apb_rsp_type rsp;
    imt_core_out_type out;
  } imt_state_type;
endpackage

// [rtl/imt_trap_control.sv]
`timescale 1ns/100ps
`include "imt_defines.svh"
// Behaviour
// - Interrupted multiply resumes from saved step and finishes after return
// - Flag clear with control word 0000h restarts multiply from first cycle
// - Upper status field F0h blocks interrupt acknowledge until software rewrites the field
// - Interrupt acknowledged enters service with global enable cleared
// - Peripheral event transfer during return never disturbs multiply state
// - Software setting NMI, overflow or underflow flag forces class A trap
// - Trap entered on the second retired instruction following flag set
// - At class A level no interrupt or hardware trap is taken
module imt_trap_control (
  input wire logic mclk,
  input wire logic rst,
  input wire imt_pkg::imt_apb_req_type apb_req,
  output imt_pkg::imt_apb_rsp_type apb_rsp,
  input wire imt_pkg::imt_core_in_type core_in,
  output imt_pkg::imt_core_out_type core_out,
  output logic irq
);
  import imt_pkg::*;

  imt_state_type state_reg, state_next;

  // Register read view; unmapped and write-only offsets read zero
  function automatic logic [31:0] read_mux(input imt_state_type s, input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `IMT_OFS_CTRL: begin
        d[`IMT_CTRL_GIE] = s.gie;
        d[`IMT_CTRL_MULTIPLY_IN_PROGRESS_FLAG] = s.multiply_in_progress_flag;
        d[`IMT_CTRL_LVL_LSB +: 4] = s.level;
        d[`IMT_CTRL_UPPER_LSB +: 8] = s.upper;
      end
      `IMT_OFS_MDC: begin
        d[15:0] = s.mdc;
      end
      `IMT_OFS_TRAP: begin
        d[`IMT_TRAP_NMI] = s.trap_flags[`IMT_TRAP_NMI];
        d[`IMT_TRAP_STACK_OVERFLOW_FLAG] = s.trap_flags[`IMT_TRAP_STACK_OVERFLOW_FLAG];
        d[`IMT_TRAP_STACK_UNDERFLOW_FLAG] = s.trap_flags[`IMT_TRAP_STACK_UNDERFLOW_FLAG];
      end
      `IMT_OFS_STAT: begin
        d[0] = (s.mode == IMT_MUL);
        d[5:1] = s.out.mul_step;
        d[6] = s.trap_pending;
        d[7] = s.class_a;
      end
      `IMT_OFS_ISTAT: begin
        d[`IMT_EV_TRAP] = s.istat[`IMT_EV_TRAP];
        d[`IMT_EV_INT] = s.istat[`IMT_EV_INT];
        d[`IMT_EV_MULDONE] = s.istat[`IMT_EV_MULDONE];
      end
      `IMT_OFS_IEN: begin
        d[2:0] = s.global_interrupt_enable;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `IMT_OFS_CTRL: hit = 1'b1;
      `IMT_OFS_MDC: hit = 1'b1;
      `IMT_OFS_TRAP: hit = 1'b1;
      `IMT_OFS_STAT: hit = 1'b1;
      `IMT_OFS_ISTAT: hit = 1'b1;
      `IMT_OFS_ICLR: hit = 1'b1;
      `IMT_OFS_IEN: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Only a flag going from clear to set arms a trap
  function automatic logic new_flag(input logic [2:0] old_flags, input logic [2:0] wdata);
    logic armed;
    armed = |(wdata & ~old_flags);
    return armed;
  endfunction

  function automatic logic [15:0] step_after(input logic [15:0] count);
    logic [15:0] nxt_count;
    nxt_count = count + 16'h0001;
    return nxt_count;
  endfunction

  // Set beats clear when an event and a clear meet in one cycle
  function automatic logic [2:0] sticky(input logic [2:0] old_bits, input logic [2:0] clr, input logic [2:0] ev_bits);
    logic [2:0] b;
    b = old_bits & ~clr;
    b = b | ev_bits;
    return b;
  endfunction

  function automatic logic irq_level(input logic [2:0] bits, input logic [2:0] mask);
    logic lvl;
    lvl = |(bits & mask);
    return lvl;
  endfunction

  // Interrupts held off by global enable, upper field or class A level
  function automatic logic int_blocked(input imt_state_type cur, input imt_state_type nxt);
    logic b;
    b = 1'b0;
    if (!nxt.gie) begin
      b = 1'b1;
    end
    if (nxt.upper == `IMT_UPPER_BLOCK) begin
      b = 1'b1;
    end
    if (cur.class_a) begin
      b = 1'b1;
    end
    return b;
  endfunction

  // Interrupt must outrank the current level; a pending forced trap goes first
  function automatic logic int_wins(input imt_state_type cur, input imt_state_type nxt, input imt_core_in_type ci);
    logic w;
    w = 1'b0;
    if (ci.int_req && ci.int_level > nxt.level) begin
      w = !cur.trap_pending;
    end
    return w;
  endfunction

  function automatic logic hw_wins(input imt_state_type cur, input imt_core_in_type ci);
    logic w;
    w = 1'b0;
    if (ci.hw_trap_req && !cur.class_a) begin
      w = 1'b1;
    end
    return w;
  endfunction

  // Forced trap falls due on the second retired instruction after the flag write
  function automatic logic trap_due(input logic [1:0] waited, input logic retire);
    logic due;
    due = 1'b0;
    if (waited == `IMT_TRAP_DELAY_MAX) begin
      due = 1'b1;
    end
    if (waited != 2'h0 && retire) begin
      due = 1'b1;
    end
    return due;
  endfunction

  // Common entry into class A level, shared by forced and hardware traps
  function automatic imt_state_type enter_trap(input imt_state_type cur, input imt_state_type nxt);
    imt_state_type r;
    r = nxt;
    r.class_a = 1'b1;
    r.out.trap_enter = 1'b1;
    r.saved_level = cur.level;
    r.mode = IMT_TRAP;
    return r;
  endfunction

  // Return restores the level and resumes or restarts the multiply
  function automatic imt_state_type on_return(input imt_state_type cur, input imt_state_type nxt, input logic start);
    imt_state_type r;
    r = nxt;
    r.level = cur.saved_level;
    r.class_a = 1'b0;
    r.gie = 1'b1;
    if (r.multiply_in_progress_flag) begin
      r.mode = IMT_MUL;
      r.out.mul_step = r.mdc[4:0];
    end else begin
      r.mode = IMT_IDLE;
    end
    if (!r.multiply_in_progress_flag && r.mdc == `IMT_MDC_RESTART && start) begin
      r.mode = IMT_MUL;
      r.multiply_in_progress_flag = 1'b1;
      r.out.mul_restart = 1'b1;
      r.out.mul_step = 5'h00;
    end
    return r;
  endfunction

  function automatic imt_state_type start_mul(input imt_state_type nxt);
    imt_state_type r;
    r = nxt;
    r.mode = IMT_MUL;
    r.multiply_in_progress_flag = 1'b1;
    r.mdc = `IMT_MDC_RESTART;
    r.out.mul_step = 5'h00;
    return r;
  endfunction

  function automatic imt_state_type write_ctrl(input imt_state_type nxt, input logic [31:0] d);
    imt_state_type r;
    r = nxt;
    r.gie = d[`IMT_CTRL_GIE];
    r.multiply_in_progress_flag = d[`IMT_CTRL_MULTIPLY_IN_PROGRESS_FLAG];
    r.level = d[`IMT_CTRL_LVL_LSB +: 4];
    r.upper = d[`IMT_CTRL_UPPER_LSB +: 8];
    return r;
  endfunction

  always_comb begin
    logic wr;
    logic rd;
    logic block_int;
    logic take_int;
    logic take_hw;
    logic [2:0] ev;
    logic [15:0] step_next;
    logic [2:0] clr;
    wr = 1'b0;
    clr = 3'b000;
    rd = 1'b0;
    block_int = 1'b0;
    take_int = 1'b0;
    take_hw = 1'b0;
    ev = 3'b000;
    step_next = 16'h0000;
    state_next = state_reg;
    state_next.out.mul_done = 1'b0;
    state_next.out.int_ack = 1'b0;
    state_next.out.pec_ack = 1'b0;
    state_next.out.trap_enter = 1'b0;
    state_next.out.mul_restart = 1'b0;
    state_next.rsp.pready = 1'b0;
    state_next.rsp.pslverr = 1'b0;

    // One wait state: answer in the second cycle of the access phase
    if (apb_req.psel && apb_req.penable && !state_reg.rsp.pready) begin
      state_next.rsp.pready = 1'b1;
      state_next.rsp.pslverr = !mapped(apb_req.paddr);
      rd = !apb_req.pwrite;
      state_next.rsp.prdata = rd ? read_mux(state_reg, apb_req.paddr) : 32'h0000_0000;
    end
    // Write lands on the edge at which the master sees pready high
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && state_reg.rsp.pready && mapped(apb_req.paddr);

    if (wr) begin
      case (apb_req.paddr)
        `IMT_OFS_CTRL: state_next = write_ctrl(state_next, apb_req.pwdata);
        `IMT_OFS_MDC: state_next.mdc = apb_req.pwdata[15:0];
        `IMT_OFS_TRAP: begin
          // Software sets flags; pending trap counts from here
          if (new_flag(state_reg.trap_flags, apb_req.pwdata[2:0])) begin
            state_next.trap_pending = 1'b1;
            state_next.trap_wait = 2'h0;
          end
          state_next.trap_flags = apb_req.pwdata[2:0];
        end
        `IMT_OFS_IEN: state_next.global_interrupt_enable = apb_req.pwdata[2:0];
        default: state_next.global_interrupt_enable = state_reg.global_interrupt_enable;
      endcase
    end

    block_int = int_blocked(state_reg, state_next);
    take_int = int_wins(state_reg, state_next, core_in) && !block_int;
    take_hw = hw_wins(state_reg, core_in);

    // Peripheral transfers are acknowledged without stalling and touch no multiply state
    if (core_in.pec_req && !state_reg.out.pec_ack) begin
      state_next.out.pec_ack = 1'b1;
    end

    // Forced trap on the second retired instruction
    if (state_reg.trap_pending && !wr) begin
      if (core_in.instr_retire) begin
        state_next.trap_wait = state_reg.trap_wait + 2'h1;
      end
      if (trap_due(state_reg.trap_wait, core_in.instr_retire)) begin
        state_next.trap_pending = 1'b0;
        state_next = enter_trap(state_reg, state_next);
        ev[`IMT_EV_TRAP] = 1'b1;
      end
    end else if (take_hw) begin
      state_next = enter_trap(state_reg, state_next);
      ev[`IMT_EV_TRAP] = 1'b1;
    end else if (take_int) begin
      // Multiply state stays as is while serviced
      state_next.out.int_ack = 1'b1;
      state_next.saved_level = state_reg.level;
      state_next.level = core_in.int_level;
      state_next.gie = 1'b0;
      state_next.mode = IMT_SERVICE;
      ev[`IMT_EV_INT] = 1'b1;
    end else begin
      case (state_reg.mode)
        IMT_IDLE: begin
          if (core_in.mul_start) begin
            state_next = start_mul(state_next);
          end
        end
        IMT_MUL: begin
          step_next = step_after(state_reg.mdc);
          state_next.mdc = step_next;
          state_next.out.mul_step = step_next[4:0];
          if (step_next[4:0] == `IMT_MUL_CYCLES) begin
            state_next.mode = IMT_IDLE;
            state_next.multiply_in_progress_flag = 1'b0;
            state_next.mdc = `IMT_MDC_RESTART;
            state_next.out.mul_done = 1'b1;
            ev[`IMT_EV_MULDONE] = 1'b1;
          end
        end
        IMT_SERVICE, IMT_TRAP: begin
          if (core_in.return_from_interrupt_instr) begin
            state_next = on_return(state_reg, state_next, core_in.mul_start);
          end
        end
        default: state_next.mode = IMT_IDLE;
      endcase
    end

    state_next.out.mul_active = (state_next.mode == IMT_MUL);
    clr = (wr && apb_req.paddr == `IMT_OFS_ICLR) ? apb_req.pwdata[2:0] : 3'b000;
    state_next.istat = sticky(state_reg.istat, clr, ev);
    state_next.irq = irq_level(state_next.istat, state_next.global_interrupt_enable);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.gie <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp = state_reg.rsp;
  assign core_out = state_reg.out;
  assign irq = state_reg.irq;
endmodule

// [dv/imt_trap_control_monitor.sv]
`timescale 1ns/100ps
module imt_trap_control_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire imt_pkg::imt_apb_req_type apb_req,
  input wire imt_pkg::imt_apb_rsp_type apb_rsp,
  input wire imt_pkg::imt_core_in_type core_in,
  input wire imt_pkg::imt_core_out_type core_out,
  input wire logic irq
);
  import imt_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic trap_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready &&
    apb_req.paddr == 12'h008 && |apb_req.pwdata[2:0];
  property p_one_wait;
    apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable |=> apb_rsp.pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_ready_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_ready;
    apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_ack_cause;
    core_out.int_ack |-> $past(core_in.int_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_once;
    core_out.int_ack |=> !core_out.int_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("second ack");
  property p_trap_in;
    trap_wr |-> ##[1:20] core_out.trap_enter;
  endproperty
  a_trap_in: assert property (p_trap_in) else $error("forced trap missing");
  property p_class_a;
    core_out.trap_enter |=> (!core_out.int_ack && !core_out.trap_enter) [*8];
  endproperty
  a_class_a: assert property (p_class_a) else $error("class A interrupted");
  property p_restart;
    core_out.mul_restart |-> ##[14:18] core_out.mul_done;
  endproperty
  a_restart: assert property (p_restart) else $error("restart length");
  property p_hold;
    !core_out.mul_active && !$past(core_out.mul_active) && !core_out.mul_restart &&
      !apb_req.psel && !$past(apb_req.psel) |-> $stable(core_out.mul_step);
  endproperty
  a_hold: assert property (p_hold) else $error("step moved");
  c_done: cover property (core_out.mul_done);
  c_ack: cover property (core_out.int_ack);
  c_trap: cover property (core_out.trap_enter);
  c_pec: cover property (core_out.pec_ack);
endmodule
bind imt_trap_control imt_trap_control_monitor mon (.mclk(mclk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .core_in(core_in), .core_out(core_out), .irq(irq));

// [dv/imt_core_model.sv]
`timescale 1ns/100ps
module imt_core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire imt_pkg::imt_core_in_type drv,
  input wire logic raise_int,
  input wire logic raise_pec,
  input wire imt_pkg::imt_core_out_type core_out,
  output imt_pkg::imt_core_in_type core_in
);
  import imt_pkg::*;
  logic [1:0] div_reg;
  logic int_reg;
  logic pec_reg;
  // Requests held until acknowledged
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_reg <= 2'h0;
      int_reg <= 1'b0;
      pec_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      int_reg <= raise_int || (int_reg && !core_out.int_ack);
      pec_reg <= raise_pec || (pec_reg && !core_out.pec_ack);
    end
  end
  always_comb begin
    core_in = drv;
    core_in.instr_retire = (div_reg == 2'h2);
    core_in.int_req = int_reg;
    core_in.pec_req = pec_reg;
  end
endmodule

// [dv/tb_imt_trap_control.sv]
`timescale 1ns/100ps
module tb_imt_trap_control;
  import imt_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic irq;
  logic ri = 1'b0;
  logic rp = 1'b0;
  imt_apb_req_type apb_req = '0;
  imt_apb_rsp_type apb_rsp;
  imt_core_in_type core_in;
  imt_core_out_type core_out;
  imt_core_in_type drv = '0;
  logic [32:0] rd;
  logic [32:0] s1;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int acks = 0;
  int traps = 0;
  int pecs = 0;
  int n;
  always #25 mclk = ~mclk;
  imt_trap_control dut (.mclk(mclk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .core_in(core_in), .core_out(core_out), .irq(irq));
  imt_core_model model (.mclk(mclk), .rst(rst), .drv(drv), .raise_int(ri), .raise_pec(rp),
    .core_out(core_out), .core_in(core_in));
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (core_out.int_ack === 1'b1) acks <= acks + 1;
    if (core_out.trap_enter === 1'b1) traps <= traps + 1;
    if (core_out.pec_ack === 1'b1) pecs <= pecs + 1;
    if (cyc == 5000) begin
      n_fail++;
      results;
    end
  end
  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk) apb_req.penable <= 1'b1;
    do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
    rd = {apb_rsp.pslverr, apb_rsp.prdata};
    apb_req <= '0;
    @(posedge mclk);
  endtask
  task automatic waitp(input int b, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (core_out[b] !== 1'b1 && k < 40);
  endtask
  task automatic kick(input logic s, input logic r, input logic p, input logic i);
    drv.mul_start <= s;
    drv.return_from_interrupt_instr <= r;
    rp <= p;
    ri <= i;
    @(posedge mclk);
    drv <= '{default: 1'b0, int_level: 4'h3};
    rp <= 1'b0;
    ri <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(0, 12'h000, 0); chk(rd, 33'h1);
    apb(0, 12'h01C, 0); chk(rd, 33'h1_0000_0000);
    apb(1, 12'h018, 32'h7);
    kick(1, 0, 0, 0); repeat (5) @(posedge mclk);
    kick(0, 0, 0, 1); waitp(7, n); chk(n <= 3, 1);
    chk(core_out.mul_active, 0);
    apb(0, 12'h000, 0); chk(rd, 33'h32);
    apb(0, 12'h00C, 0); s1 = rd;
    apb(0, 12'h00C, 0); chk(rd, s1);
    kick(0, 1, 1, 0); waitp(8, n); chk(n < 16, 1);
    chk(pecs, 1);
    chk(irq, 1);
    apb(0, 12'h010, 0); chk(rd, 33'h6);
    apb(1, 12'h014, 32'h7); chk(irq, 0);
    apb(1, 12'h000, 32'h1);
    $display("test resume done");
    kick(1, 0, 0, 0); repeat (5) @(posedge mclk);
    kick(0, 0, 0, 1); waitp(7, n);
    apb(1, 12'h000, 32'h30);
    apb(1, 12'h004, 0);
    kick(1, 1, 0, 0); waitp(9, n); chk(n <= 3, 1);
    waitp(8, n); chk(n >= 14, 1);
    apb(1, 12'h000, 32'h0000F001);
    s1 = acks;
    kick(0, 0, 0, 1); repeat (10) @(posedge mclk); chk(acks, s1);
    apb(1, 12'h000, 32'h1); repeat (3) @(posedge mclk); chk(acks, s1 + 1);
    kick(0, 1, 0, 0); apb(1, 12'h000, 32'h1);
    $display("test restart done");
    for (int f = 0; f < 3; f++) begin
      apb(1, 12'h008, 32'h1 << f); repeat (8) @(posedge mclk); chk(traps, f + 1);
      drv.hw_trap_req <= 1'b1; repeat (4) @(posedge mclk); chk(traps, f + 1);
      drv.hw_trap_req <= 1'b0;
      apb(1, 12'h008, 0);
      kick(0, 1, 0, 0);
    end
    apb(1, 12'h018, 0); chk(irq, 0);
    $display("test traps done");
    results;
  end
endmodule
